/* File: logic/tspf_map.svh */
// Register map, field positions and timing constants of the scan pacer.
// Assumes inclusion by the package and by every design file that decodes fields.
`ifndef TSPF_MAP_SVH
`define TSPF_MAP_SVH

`define TSPF_CFG_ADDR        4'hE
`define TSPF_CFG_RESET       16'h0000
`define TSPF_CFG_WMASK       16'hFC1E
`define TSPF_BIT_FORMAT      15
`define TSPF_BIT_SOURCE      14
`define TSPF_FLT_M_HI        13
`define TSPF_FLT_M_LO        12
`define TSPF_FLT_W_HI        11
`define TSPF_FLT_W_LO        10
`define TSPF_EN_X            4
`define TSPF_EN_Y            3
`define TSPF_EN_Z            2
`define TSPF_EN_AUX          1
`define TSPF_CLK_HZ          10000000
`define TSPF_US_PER_MS       1000
`define TSPF_TICK_US         1000
`define TSPF_TICK_CYC        ((`TSPF_CLK_HZ / 1000000) * `TSPF_TICK_US)
`define TSPF_TD_1            8'h01
`define TSPF_TD_2            8'h02
`define TSPF_TD_4            8'h04
`define TSPF_TD_10           8'h0A
`define TSPF_TD_20           8'h14
`define TSPF_TD_40           8'h28
`define TSPF_TD_100          8'h64

`endif

/* File: logic/tspf_pkg.sv */
// Types shared by the scan pacer, its port checker and its bench.
// Assumes the constants header sits beside it.
`include "tspf_map.svh"
package tspf_pkg;
  typedef enum logic [1:0] {
    TSPF_IDLE = 2'b00,
    TSPF_SET  = 2'b01,
    TSPF_WAIT = 2'b10
  } tspf_state_t;

  typedef struct packed {
    logic       format_sel;
    logic       source_sel;
    logic [1:0] flt_m;
    logic [1:0] flt_w;
    logic [3:0] flt_en;
  } tspf_cfg_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [15:0] wdata;
  } tspf_bus_t;
endpackage

/* File: logic/tspf_delay_timer.sv */
// Batch-delay timer: counts whole milliseconds down from a loaded value.
// Assumes a 10 MHz clock with one enable that freezes the count.
`timescale 1ns/100ps
`default_nettype none
`include "tspf_map.svh"
module tspf_delay_timer #(
  parameter int TICK_CYC = `TSPF_TICK_CYC
) (
  // Clock and control
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       load,
  input  wire logic [7:0] load_ms,
  // Status
  output logic            expired
);
  logic [15:0] tick_ff;
  logic [15:0] nxt_tick;
  logic [7:0]  ms_ff;
  logic [7:0]  nxt_ms;

  always_comb begin
    nxt_tick = tick_ff;
    nxt_ms   = ms_ff;
    if (load) begin
      nxt_tick = 16'h0000;
      nxt_ms   = load_ms;
    end else if (ms_ff != 8'h00) begin
      if (tick_ff == 16'(TICK_CYC - 1)) begin
        nxt_tick = 16'h0000;
        nxt_ms   = ms_ff - 8'h01;
      end else begin
        nxt_tick = tick_ff + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tick_ff <= 16'h0000;
      ms_ff   <= 8'h00;
    end else if (ce) begin
      tick_ff <= nxt_tick;
      ms_ff   <= nxt_ms;
    end
  end

  assign expired = (ms_ff == 8'h00);
endmodule
`default_nettype wire

/* File: logic/tspf_pacer.sv */
// Scan pacer with batch delay and the preprocessor configuration register.
// Assumes the converter core reports set completion and busy on this clock.
`timescale 1ns/100ps
`default_nettype none
`include "tspf_map.svh"
module tspf_pacer
  import tspf_pkg::*;
(
  // Clock, enable and reset
  input  wire logic                CLK,
  input  wire logic                CE,
  input  wire logic                RESET,
  // Register port
  input  wire tspf_pkg::tspf_bus_t BUS,
  output logic [15:0]              RDATA,
  // Scan control and core status
  input  wire logic [2:0]          BATCH_DELAY_CODE,
  input  wire logic                SCAN_ENABLE,
  input  wire logic                STOP_CMD,
  input  wire logic                SOFT_RESET,
  input  wire logic                PEN_TOUCH_PIN,
  input  wire logic                SET_DONE,
  input  wire logic                CORE_BUSY,
  input  wire logic                FILTER_PENDING,
  input  wire logic                DATA_READY,
  // Scan and status outputs
  output logic                     START_SET,
  output logic                     CONVERTER_BUSY_STOP,
  output logic                     DATA_AVAIL_FLAG,
  output tspf_pkg::tspf_cfg_t      FILTER_CFG,
  output logic                     TOUCH_IRQ_DATA_PIN_N
);
  import tspf_pkg::*;

  logic [15:0] cfg_ff;
  logic [15:0] nxt_cfg;
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;
  tspf_state_t state_ff;
  tspf_state_t nxt_state;
  logic        start_ff;
  logic        nxt_start;
  logic        load;
  logic [7:0]  load_ms;
  logic        expired;
  logic        pen_s1_ff;
  logic        pen_s2_ff;
  logic        pin_ff;
  logic        nxt_pin;
  logic        busy_ff;
  logic        nxt_busy;
  logic        dav_ff;
  logic        nxt_dav;

  // Pen detect comes from the analog comparator, so it is synchronised first.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      pen_s1_ff <= 1'b0;
      pen_s2_ff <= 1'b0;
    end else if (CE) begin
      pen_s1_ff <= PEN_TOUCH_PIN;
      pen_s2_ff <= pen_s1_ff;
    end
  end

  // Configuration register; reserved bits are dropped on write and read as zero.
  always_comb begin
    nxt_cfg   = cfg_ff;
    nxt_rdata = rdata_ff;
    if (SOFT_RESET) begin
      nxt_cfg = `TSPF_CFG_RESET;
    end else if (BUS.wr && BUS.addr == `TSPF_CFG_ADDR) begin
      nxt_cfg = BUS.wdata & `TSPF_CFG_WMASK;
    end
    if (BUS.rd) begin
      nxt_rdata = (BUS.addr == `TSPF_CFG_ADDR) ? cfg_ff : 16'h0000;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      cfg_ff   <= `TSPF_CFG_RESET;
      rdata_ff <= 16'h0000;
    end else if (CE) begin
      cfg_ff   <= nxt_cfg;
      rdata_ff <= nxt_rdata;
    end
  end

  assign RDATA = rdata_ff;
  assign FILTER_CFG.format_sel = cfg_ff[`TSPF_BIT_FORMAT];
  assign FILTER_CFG.source_sel = cfg_ff[`TSPF_BIT_SOURCE];
  assign FILTER_CFG.flt_m      = cfg_ff[`TSPF_FLT_M_HI:`TSPF_FLT_M_LO];
  assign FILTER_CFG.flt_w      = cfg_ff[`TSPF_FLT_W_HI:`TSPF_FLT_W_LO];
  assign FILTER_CFG.flt_en     = cfg_ff[`TSPF_EN_X:`TSPF_EN_AUX];

  // Delay code to whole milliseconds between set starts.
  always_comb begin
    case (BATCH_DELAY_CODE)
      3'h1:    load_ms = `TSPF_TD_1;
      3'h2:    load_ms = `TSPF_TD_2;
      3'h3:    load_ms = `TSPF_TD_4;
      3'h4:    load_ms = `TSPF_TD_10;
      3'h5:    load_ms = `TSPF_TD_20;
      3'h6:    load_ms = `TSPF_TD_40;
      3'h7:    load_ms = `TSPF_TD_100;
      default: load_ms = 8'h00;
    endcase
  end

  // The timer runs during the set itself, so a long set simply finds it expired.
  always_comb begin
    nxt_state = state_ff;
    nxt_start = 1'b0;
    load      = 1'b0;
    if (STOP_CMD || SOFT_RESET || !SCAN_ENABLE) begin
      nxt_state = TSPF_IDLE;
    end else begin
      case (state_ff)
        TSPF_IDLE: begin
          if (pen_s2_ff) begin
            nxt_state = TSPF_SET;
            nxt_start = 1'b1;
            load      = 1'b1;
          end
        end
        TSPF_SET: begin
          if (SET_DONE) begin
            nxt_state = TSPF_WAIT;
          end
        end
        TSPF_WAIT: begin
          if (!pen_s2_ff) begin
            nxt_state = TSPF_IDLE;
          end else if (expired) begin
            nxt_state = TSPF_SET;
            nxt_start = 1'b1;
            load      = 1'b1;
          end
        end
        default: nxt_state = TSPF_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      state_ff <= TSPF_IDLE;
      start_ff <= 1'b0;
    end else if (CE) begin
      state_ff <= nxt_state;
      start_ff <= nxt_start;
    end
  end

  assign START_SET = start_ff;

  tspf_delay_timer #(
    .TICK_CYC (`TSPF_TICK_CYC)
  ) u_timer (
    .clk     (CLK),
    .rst     (RESET),
    .ce      (CE),
    .load    (load),
    .load_ms (load_ms),
    .expired (expired)
  );

  // Busy is held high and data-available held off until filter conversions finish.
  always_comb begin
    nxt_busy = CORE_BUSY | FILTER_PENDING;
    nxt_dav  = DATA_READY & ~FILTER_PENDING;
    if (FILTER_CFG.source_sel) begin
      nxt_pin = ~nxt_dav;
    end else if (FILTER_CFG.format_sel) begin
      nxt_pin = ~pen_s2_ff;
    end else begin
      nxt_pin = ~pen_s2_ff & ~nxt_dav;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      busy_ff <= 1'b0;
      dav_ff  <= 1'b0;
      pin_ff  <= 1'b1;
    end else if (CE) begin
      busy_ff <= nxt_busy;
      dav_ff  <= nxt_dav;
      pin_ff  <= nxt_pin;
    end
  end

  assign CONVERTER_BUSY_STOP  = busy_ff;
  assign DATA_AVAIL_FLAG      = dav_ff;
  assign TOUCH_IRQ_DATA_PIN_N = pin_ff;
endmodule
`default_nettype wire

/* File: bench/tspf_pacer_props.sv */
// Port checker for the scan pacer.
// Assumes CE is held high, so every edge counts.
`timescale 1ns/100ps
`default_nettype none
module tspf_pacer_props
  import tspf_pkg::*;
(
  input wire logic                CLK,
  input wire logic                RESET,
  input wire logic                SOFT_RESET,
  input wire logic                PEN_TOUCH_PIN,
  input wire tspf_pkg::tspf_bus_t BUS,
  input wire logic [15:0]         RDATA,
  input wire logic [2:0]          BATCH_DELAY_CODE,
  input wire logic                CORE_BUSY,
  input wire logic                FILTER_PENDING,
  input wire logic                START_SET,
  input wire logic                CONVERTER_BUSY_STOP,
  input wire logic                DATA_AVAIL_FLAG,
  input wire tspf_pkg::tspf_cfg_t FILTER_CFG,
  input wire logic                TOUCH_IRQ_DATA_PIN_N
);
  logic [15:0] gap_ff;
  logic [15:0] nxt_gap;
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  // Saturates so a first set after reset or after a lifted pen never looks early.
  always_comb nxt_gap = START_SET ? 16'h0001 : !PEN_TOUCH_PIN ? 16'hFFFF :
    gap_ff + {15'h0000, gap_ff != 16'hFFFF};
  always_ff @(posedge CLK) gap_ff <= RESET ? 16'hFFFF : nxt_gap;
  busy_follow_a: assert property (
    !$past(RESET) |-> CONVERTER_BUSY_STOP == $past(CORE_BUSY | FILTER_PENDING))
    else $error("busy lag wrong");
  cfg_write_a: assert property (
    BUS.wr && !SOFT_RESET && BUS.addr == 4'hE |=>
      FILTER_CFG == {$past(BUS.wdata[15:10]), $past(BUS.wdata[4:1])})
    else $error("config write wrong");
  cfg_read_a: assert property (
    BUS.rd && !BUS.wr |=> RDATA == ($past(BUS.addr) == 4'hE ?
      {$past(FILTER_CFG[9:4]), 5'h00, $past(FILTER_CFG[3:0]), 1'b0} : 16'h0000))
    else $error("read data wrong");
  rdata_hold_a: assert property (!BUS.rd |=> $stable(RDATA))
    else $error("read data moved");
  reset_state_a: assert property (disable iff (1'b0)
    RESET |=> RDATA == 16'h0000 && FILTER_CFG == '0 && !START_SET && TOUCH_IRQ_DATA_PIN_N)
    else $error("reset state wrong");
  set_pulse_a: assert property (START_SET |=> !START_SET)
    else $error("start too long");
  rate_gap_a: assert property (
    START_SET && BATCH_DELAY_CODE == 3'b001 |-> gap_ff >= 16'h2710)
    else $error("set started early");
  pin_data_a: assert property (
    (FILTER_CFG.source_sel && $stable(DATA_AVAIL_FLAG)) [*3] |-> TOUCH_IRQ_DATA_PIN_N == !DATA_AVAIL_FLAG)
    else $error("pin not data flag");
endmodule
`default_nettype wire

/* File: bench/tspf_core_model.sv */
// Converter core stand-in: ends each sample set a chosen time after it starts.
// Assumes the start pulse lasts one cycle of the pacer clock.
`timescale 1ns/100ps
`default_nettype none
module tspf_core_model (
  input  wire logic        clk,
  input  wire logic        start,
  input  wire logic [15:0] dly,
  output logic             done
);
  logic [15:0] cnt = 16'h0000;
  initial done = 1'b0;
  always @(posedge clk) begin
    done <= start ? 1'b0 : cnt == 16'h0001;
    cnt <= start ? dly : cnt - {15'h0000, cnt != 16'h0000};
  end
endmodule
`default_nettype wire

/* File: bench/test_tspf_pacer.sv */
// Self-checking bench for the scan pacer.
// Assumes the core model answers every set and CE stays high.
`timescale 1ns/100ps
`default_nettype none
module test_tspf_pacer;
  import tspf_pkg::*;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  tspf_bus_t   bus = '0;
  logic [2:0]  code = 3'b001;
  logic        stop = 1'b0;
  logic        sreset = 1'b0;
  logic        pen = 1'b0;
  logic        busy = 1'b0;
  logic        fpend = 1'b0;
  logic        dready = 1'b0;
  logic [15:0] dly = 16'd40;
  logic [15:0] rdata;
  logic        start_set;
  logic        set_done;
  logic        busy_stop;
  logic        data_avail_flag;
  tspf_cfg_t   cfg;
  logic        pin_n;
  int          fails = 0;
  int          check_count = 0;
  int          gap;
  logic [19:0] tbl [6] = '{20'h4000C, 20'h4000F, 20'h80005, 20'h80008, 20'h00004, 20'h00001};
  initial forever #50 clk = ~clk;
  tspf_pacer dut_u (.CLK(clk), .CE(1'b1), .RESET(reset), .BUS(bus), .RDATA(rdata),
    .BATCH_DELAY_CODE(code), .SCAN_ENABLE(1'b1), .STOP_CMD(stop), .SOFT_RESET(sreset),
    .PEN_TOUCH_PIN(pen), .SET_DONE(set_done), .CORE_BUSY(busy), .FILTER_PENDING(fpend),
    .DATA_READY(dready), .START_SET(start_set), .CONVERTER_BUSY_STOP(busy_stop),
    .DATA_AVAIL_FLAG(data_avail_flag), .FILTER_CFG(cfg), .TOUCH_IRQ_DATA_PIN_N(pin_n));
  tspf_core_model core_u (.clk(clk), .start(start_set), .dly(dly), .done(set_done));
  task automatic test_done();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d);
    bus = '{wr: w, rd: !w, addr: a, wdata: d};
    tick(1);
    bus = '0;
    tick(1);
    if (!w) chk(rdata, d);
  endtask
  task automatic wait_start(input int lim);
    gap = 0;
    while (start_set !== 1'b1) begin
      tick(1);
      gap++;
      if (gap > lim) begin
        chk(16'h0000, 16'h0001);
        test_done();
      end
    end
    tick(1);
  endtask
  task automatic quiet(input int n);
    gap = 0;
    repeat (n) begin
      tick(1);
      gap += int'(start_set === 1'b1);
    end
    chk(16'(gap), 16'h0000);
  endtask
  initial begin
    tick(6);
    reset = 1'b0;
    pen = 1'b1;
    wait_start(20);
    wait_start(10100);
    chk(16'(gap >= 9999 && gap <= 10002), 16'h0001);
    dly = 16'd12000;
    wait_start(10100);
    code = 3'b000;
    dly = 16'd40;
    wait_start(12100);
    chk(16'(gap >= 11998 && gap <= 12004), 16'h0001);
    wait_start(100);
    chk(16'(gap >= 38 && gap <= 46), 16'h0001);
    stop = 1'b1;
    tick(3);
    quiet(200);
    pen = 1'b0;
    tick(5);
    stop = 1'b0;
    quiet(200);
    pen = 1'b1;
    wait_start(20);
    pen = 1'b0;
    quiet(200);
    $display("scan test done");
    acc(1'b0, 4'hE, 16'h0000);
    acc(1'b1, 4'hE, 16'hFC1E);
    chk({6'h00, cfg}, 16'h03FF);
    acc(1'b0, 4'hE, 16'hFC1E);
    acc(1'b1, 4'h3, 16'h0000);
    acc(1'b0, 4'hE, 16'hFC1E);
    acc(1'b0, 4'hD, 16'h0000);
    sreset = 1'b1;
    tick(1);
    sreset = 1'b0;
    tick(1);
    chk({6'h00, cfg}, 16'h0000);
    acc(1'b0, 4'hE, 16'h0000);
    acc(1'b1, 4'hE, 16'h0012);
    chk({12'h000, cfg.flt_en}, 16'h0009);
    $display("register test done");
    foreach (tbl[i]) begin
      acc(1'b1, 4'hE, tbl[i][19:4]);
      pen = tbl[i][3];
      dready = tbl[i][2];
      fpend = tbl[i][1];
      busy = tbl[i][2];
      tick(6);
      chk({15'h0000, pin_n}, {15'h0000, tbl[i][0]});
      chk({15'h0000, busy_stop}, {15'h0000, tbl[i][2] | tbl[i][1]});
      chk({15'h0000, data_avail_flag}, {15'h0000, tbl[i][2] & ~tbl[i][1]});
    end
    $display("pin test done");
    test_done();
  end
endmodule
bind tspf_pacer tspf_pacer_props props_u (.CLK(CLK), .RESET(RESET), .SOFT_RESET(SOFT_RESET),
  .PEN_TOUCH_PIN(PEN_TOUCH_PIN), .BUS(BUS), .RDATA(RDATA),
  .BATCH_DELAY_CODE(BATCH_DELAY_CODE), .CORE_BUSY(CORE_BUSY), .FILTER_PENDING(FILTER_PENDING),
  .START_SET(START_SET), .CONVERTER_BUSY_STOP(CONVERTER_BUSY_STOP),
  .DATA_AVAIL_FLAG(DATA_AVAIL_FLAG), .FILTER_CFG(FILTER_CFG),
  .TOUCH_IRQ_DATA_PIN_N(TOUCH_IRQ_DATA_PIN_N));
`default_nettype wire
